// *** src/kbc_fifo.sv ***
`timescale 1ns/1ps
// Receive FIFO; read data always come out of the output register
module kbc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input wire logic   clk,   // System clock
    input wire logic   rstn,  // Synchronous reset, active low
    kbc_stream_if.snk  wr,    // Fill side
    kbc_stream_if.src  rd     // Drain side
);
    localparam int            AW   = $clog2(DEPTH);
    localparam logic [AW:0]   FULL = DEPTH[AW:0];

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   cnt;
    logic          out_v;
    logic [W-1:0]  out_d;

    // Handshakes; the output register adds one word beyond DEPTH
    wire           push     = wr.valid & wr.ready;
    wire           load     = (cnt != '0) & (~out_v | rd.ready);
    wire  [AW:0]   next_cnt = cnt + {{AW{1'b0}}, push}
                                  - {{AW{1'b0}}, load};
    assign wr.ready = (cnt != FULL);
    assign rd.valid = out_v;
    assign rd.data  = out_d;

    // Storage needs no reset
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wptr] <= wr.data;
    end

    // Pointers and occupancy
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wptr <= '0;
            rptr <= '0;
            cnt  <= '0;
        end
        else
        begin
            wptr <= push ? wptr + 1'b1 : wptr;
            rptr <= load ? rptr + 1'b1 : rptr;
            cnt  <= next_cnt;
        end
    end

    // Registered read port
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            out_v <= 1'b0;
            out_d <= '0;
        end
        else if (load)
        begin
            out_v <= 1'b1;
            out_d <= mem[rptr];
        end
        else if (rd.ready)
            out_v <= 1'b0;
    end

    property p_fifo_bound;
        @(posedge clk) disable iff (!rstn)
        push |=> cnt != '0;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound)
        else $error("fifo lost a pushed word");
endmodule

// *** src/kbc_pkg.sv ***
package kbc_pkg;

    // Host side decode
    localparam logic [15:0] DATA_PORT    = 16'h0060;
    localparam int          BYTE_W       = 8;

    // Clock rate and link inhibit time before a transmit
    localparam int          SYS_CLK_HZ   = 10_000_000;
    localparam int          INHIBIT_US   = 100;
    localparam int          INH_CYC      =
        (INHIBIT_US * SYS_CLK_HZ + 999_999) / 1_000_000;
    localparam logic [15:0] INH_LAST     = 16'(INH_CYC - 1);

    // Frame layout: count of link clock falls after the start bit, less one
    localparam logic [3:0]  FRAME_LAST   = 4'h9;
    localparam int          TX_FRAME_W   = 11;

    // Codes placed in the output buffer
    localparam logic [7:0]  BRK_PREFIX   = 8'hF0;
    localparam logic [7:0]  BRK_BIT      = 8'h80;
    localparam logic [7:0]  ERR_CODE     = 8'hFF;
    localparam logic [7:0]  TX_FAIL_CODE = 8'hFE;

    // Receive buffering
    localparam int          FIFO_DEPTH   = 8;

    // Link sequencer states
    typedef enum logic [5:0] {
        S_IDLE  = 6'h01,
        S_RX    = 6'h02,
        S_RXACK = 6'h04,
        S_INH   = 6'h08,
        S_TX    = 6'h10,
        S_TXACK = 6'h20
    } kbc_state_t;

endpackage

// *** src/kbc_stream_if.sv ***
`timescale 1ns/1ps
// Byte stream into the receive FIFO from the link sequencer, and out of it to the output buffer
interface kbc_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// *** src/kbc_top.sv ***
`timescale 1ns/1ps
// Keyboard link controller: serial link to the keyboard, byte port to host
module kbc_top
    import kbc_pkg::*;
(
    input  wire logic        sys_clk,      // System clock, 10 MHz
    input  wire logic        rstn,         // Synchronous reset, active low
    input  wire logic [15:0] io_addr,      // Host I/O address
    input  wire logic        io_rd,        // Host read strobe
    input  wire logic        io_wr,        // Host write strobe
    input  wire logic [7:0]  io_wdata,     // Host write data
    output logic      [7:0]  io_rdata,     // Host read data, registered
    input  wire logic        irq_en,       // Allow the buffer interrupt
    output logic             irq,          // Output buffer full interrupt
    input  wire logic        xlat_en,      // Break code translation on
    output logic             stat_obf,     // Output buffer full
    output logic             stat_ibf,     // Transmit byte pending
    output logic             stat_par_err, // Receive parity/frame error
    output logic             stat_tx_err,  // Keyboard did not acknowledge
    input  wire logic        kb_clk_in,    // Link clock pin level
    output logic             kb_clk_out,   // Link clock drive value
    output logic             kb_clk_oe,    // Link clock pulled low
    input  wire logic        kb_data_in,   // Link data pin level
    output logic             kb_data_out,  // Link data drive value
    output logic             kb_data_oe    // Link data pulled low
);
    import kbc_pkg::*;

    function automatic logic is_data_port(input logic [15:0] a);
        is_data_port = (a == DATA_PORT);
    endfunction

    kbc_state_t           st;
    kbc_state_t           next_st;
    logic                 clk_m;
    logic                 clk_s;
    logic                 clk_d;
    logic                 data_m;
    logic                 data_s;
    logic [3:0]           cnt;
    logic [15:0]          icnt;
    logic [7:0]           rx_sh;
    logic                 rx_par;
    logic [TX_FRAME_W-1:0] tx_sh;
    logic [7:0]           tx_hold;
    logic                 ibf;
    logic                 brk;
    logic                 push_v;
    logic [7:0]           push_d;
    logic [7:0]           obuf;
    logic                 obf;
    logic                 par_err;
    logic                 tx_err;

    kbc_stream_if #(.W(BYTE_W)) in_s ();
    kbc_stream_if #(.W(BYTE_W)) out_s ();

    kbc_fifo #(
        .W     (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk  (sys_clk),
        .rstn (rstn),
        .wr   (in_s),
        .rd   (out_s)
    );

    // Pin synchronisers; link idles high
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            clk_m  <= 1'b1;
            clk_s  <= 1'b1;
            clk_d  <= 1'b1;
            data_m <= 1'b1;
            data_s <= 1'b1;
        end
        else
        begin
            clk_m  <= kb_clk_in;
            clk_s  <= clk_m;
            clk_d  <= clk_s;
            data_m <= kb_data_in;
            data_s <= clk_s ? data_m : data_s;
        end
    end

    // Host decode and link event decode
    wire       rd_hit   = io_rd & is_data_port(io_addr);
    wire       wr_hit   = io_wr & is_data_port(io_addr);
    wire       fall     = clk_d & ~clk_s;
    wire       rx_end   = (st == S_RX) & fall & (cnt == FRAME_LAST);
    wire       tx_end   = (st == S_TXACK) & fall;
    wire       wr_take  = wr_hit & (~ibf | tx_end);
    wire       tx_nack  = tx_end & data_s;
    wire       odd_ok   = ^{rx_sh, rx_par};
    wire       frame_ok = odd_ok & data_s;
    wire [7:0] rx_code  = frame_ok ? rx_sh : ERR_CODE;
    wire       is_pref  = xlat_en & frame_ok & (rx_code == BRK_PREFIX);
    wire [7:0] xl_code  = (xlat_en & brk) ? (rx_code | BRK_BIT)
                                          : rx_code;
    wire       ob_load  = out_s.valid & out_s.ready;

    // Buffer hand-offs; a host read frees the buffer in the same cycle
    assign in_s.valid  = push_v;
    assign in_s.data   = push_d;
    assign out_s.ready = ~obf | rd_hit;

    // Open-drain link pins: only ever pull low
    assign kb_clk_out  = 1'b0;
    assign kb_data_out = 1'b0;
    // Holding the clock low while the FIFO is full stalls the keyboard
    assign kb_clk_oe   = (st == S_INH) | ((st == S_IDLE) & ~in_s.ready);
    assign kb_data_oe  = (st == S_RXACK)
                       | ((st == S_TX) & ~tx_sh[0]);

    // Status and interrupt; the line follows output buffer full only
    assign irq          = obf & irq_en;
    assign stat_obf     = obf;
    assign stat_ibf     = ibf;
    assign stat_par_err = par_err;
    assign stat_tx_err  = tx_err;

    // Link sequencer
    always_comb
    begin
        next_st = st;
        unique case (st)
            S_IDLE:
                if (fall & ~data_s & in_s.ready)
                    next_st = S_RX;
                else if (ibf & in_s.ready)
                    next_st = S_INH;
            S_RX:
                if (rx_end)
                    next_st = S_RXACK;
            S_RXACK:
                if (fall)
                    next_st = S_IDLE;
            S_INH:
                if (icnt == INH_LAST)
                    next_st = S_TX;
            S_TX:
                if (fall & (cnt == FRAME_LAST))
                    next_st = S_TXACK;
            S_TXACK:
                if (fall)
                    next_st = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            st <= S_IDLE;
        else
            st <= next_st;
    end

    // Bit and inhibit counters
    always_ff @(posedge sys_clk)
    begin
        if (!rstn || st != next_st)
            cnt <= 4'h0;
        else if (fall & ((st == S_RX) | (st == S_TX)))
            cnt <= cnt + 4'h1;
        if (!rstn || st != S_INH)
            icnt <= 16'h0000;
        else
            icnt <= icnt + 16'h0001;
    end

    // Receive shifter, LSB first, then parity
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            rx_sh  <= 8'h00;
            rx_par <= 1'b0;
        end
        else if ((st == S_RX) & fall & (cnt < 4'h8))
            rx_sh  <= {data_s, rx_sh[7:1]};
        else if ((st == S_RX) & fall & (cnt == 4'h8))
            rx_par <= data_s;
    end

    // Transmit shifter; parity inserted at load time
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            tx_sh <= {TX_FRAME_W{1'b1}};
        else if ((st == S_IDLE) & (next_st == S_INH))
            tx_sh <= {1'b1, ~^tx_hold, tx_hold, 1'b0};
        else if ((st == S_TX) & fall)
            tx_sh <= {1'b1, tx_sh[TX_FRAME_W-1:1]};
    end

    // Host transmit holding byte; refused while one is outstanding
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            ibf     <= 1'b0;
            tx_hold <= 8'h00;
        end
        else if (wr_take)
        begin
            ibf     <= 1'b1;
            tx_hold <= io_wdata;
        end
        else if (tx_end)
            ibf     <= 1'b0;
    end

    // Received or failure byte into the FIFO
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            push_v <= 1'b0;
            push_d <= 8'h00;
            brk    <= 1'b0;
        end
        else
        begin
            push_v <= (rx_end & ~is_pref) | tx_nack;
            push_d <= tx_nack ? TX_FAIL_CODE : xl_code;
            brk    <= rx_end ? is_pref : brk;
        end
    end

    // Output buffer; a new byte wins over the read that frees it
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            obf      <= 1'b0;
            obuf     <= 8'h00;
            io_rdata <= 8'h00;
        end
        else
        begin
            if (ob_load)
                obuf <= out_s.data;
            obf      <= ob_load | (obf & ~rd_hit);
            io_rdata <= rd_hit ? obuf : io_rdata;
        end
    end

    // Sticky error flags; set beats clear
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            par_err <= 1'b0;
            tx_err  <= 1'b0;
        end
        else
        begin
            par_err <= (rx_end & ~frame_ok) | (par_err & ~rd_hit);
            tx_err  <= tx_nack | (tx_err & ~wr_take);
        end
    end

    property p_rx_to_ack;
        @(posedge sys_clk) disable iff (!rstn)
        rx_end |=> (st == S_RXACK) && kb_data_oe;
    endproperty
    a_rx_to_ack: assert property (p_rx_to_ack)
        else $error("no acknowledge after receive");

    property p_rx_push;
        @(posedge sys_clk) disable iff (!rstn)
        rx_end && !is_pref |=> in_s.valid && in_s.data == $past(xl_code);
    endproperty
    a_rx_push: assert property (p_rx_push)
        else $error("received byte not pushed");

    property p_par_flag;
        @(posedge sys_clk) disable iff (!rstn)
        rx_end && !odd_ok |=> par_err && push_d == ERR_CODE;
    endproperty
    a_par_flag: assert property (p_par_flag)
        else $error("parity error not reported");

    property p_irq_src;
        @(posedge sys_clk) disable iff (!rstn)
        $rose(obf) && irq_en |-> irq ##1 (irq || !obf);
    endproperty
    a_irq_src: assert property (p_irq_src)
        else $error("interrupt not raised on buffer load");

    property p_poll_clear;
        @(posedge sys_clk) disable iff (!rstn)
        rd_hit && obf && !out_s.valid |=> !stat_obf;
    endproperty
    a_poll_clear: assert property (p_poll_clear)
        else $error("buffer full stuck after read");

    property p_wr_take;
        @(posedge sys_clk) disable iff (!rstn)
        wr_hit && !ibf |=> ibf && tx_hold == $past(io_wdata);
    endproperty
    a_wr_take: assert property (p_wr_take)
        else $error("host write not taken");

    property p_tx_parity;
        @(posedge sys_clk) disable iff (!rstn)
        st == S_IDLE && next_st == S_INH |=> ^tx_sh[9:1] && !tx_sh[0];
    endproperty
    a_tx_parity: assert property (p_tx_parity)
        else $error("transmit frame parity wrong");

    property p_hold_off;
        @(posedge sys_clk) disable iff (!rstn)
        wr_hit && ibf && !tx_end |=> $stable(tx_hold);
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("byte replaced before acknowledge");

    property p_nack_report;
        @(posedge sys_clk) disable iff (!rstn)
        tx_nack |-> ##[1:6] obf;
    endproperty
    a_nack_report: assert property (p_nack_report)
        else $error("transmit failure not reported");

    property p_port_decode;
        @(posedge sys_clk) disable iff (!rstn)
        io_rd && io_addr != DATA_PORT && obf |=> obf;
    endproperty
    a_port_decode: assert property (p_port_decode)
        else $error("foreign address touched buffer");

    property p_tx_start;
        @(posedge sys_clk) disable iff (!rstn)
        st == S_INH && next_st == S_TX |=> kb_data_oe && !kb_clk_oe;
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("start bit not driven low");
endmodule

// *** verif/kbc_kbd_model.sv ***
`timescale 1ns/1ps
// Keyboard at the far end of the link; both lines open drain, pulled up
module kbc_kbd_model (
    input  wire logic       kb_clk,   // Link clock wire level
    input  wire logic       kb_data,  // Link data wire level
    input  wire logic       ack_en,   // Acknowledge frames from the device
    output logic            clk_oe,   // Pull clock low
    output logic            data_oe,  // Pull data low
    output logic [7:0]      rx_byte,  // Last byte taken from the device
    output logic            rx_par,   // Its parity bit
    output logic            rx_stop,  // Its stop bit
    output logic [7:0]      rx_cnt,   // Frames taken from the device
    output logic            ack_seen  // Device acknowledged the last send
);
    localparam time HALF = 400ns;
    logic        sending;
    logic [10:0] frm;

    // Clock stands still between frames
    initial
    begin
        clk_oe   = 1'h0;
        data_oe  = 1'h0;
        sending  = 1'h0;
        rx_byte  = 8'h00;
        rx_par   = 1'h0;
        rx_stop  = 1'h0;
        rx_cnt   = 8'h00;
        ack_seen = 1'h0;
    end

    // Send one frame; bad flips the parity bit to provoke an error
    task automatic send_byte(input logic [7:0] b, input logic bad);
        sending = 1'h1;
        frm = {1'h1, ~^b ^ bad, b, 1'h0};
        wait (kb_clk === 1'h1); // Device may inhibit us
        for (int i = 0; i < 11; i++)
        begin
            data_oe = ~frm[i]; // Data changes only while clock is high
            #HALF clk_oe = 1'h1;
            #HALF clk_oe = 1'h0;
        end
        data_oe = 1'h0;
        // Extra clock during which the device must pull data low
        #HALF clk_oe = 1'h1;
        #(HALF / 2) ack_seen = (kb_data === 1'h0);
        #(HALF / 2) clk_oe = 1'h0;
        #HALF sending = 1'h0;
    endtask

    // Device frame: start seen as data low with the clock released
    always
    begin
        @(negedge kb_data);
        // Both device pins move in one step; let the clock settle first
        #10;
        if (!sending && kb_clk === 1'h1)
        begin
            for (int i = 0; i < 10; i++)
            begin
                #HALF clk_oe = 1'h1;
                #HALF clk_oe = 1'h0;
                // Sample on the rising edge
                if (i < 8)
                    rx_byte[i] = kb_data;
                else if (i == 8)
                    rx_par = kb_data;
                else
                    rx_stop = kb_data;
            end
            data_oe = ack_en;
            #HALF clk_oe = 1'h1;
            #HALF clk_oe = 1'h0;
            data_oe = 1'h0;
            rx_cnt = rx_cnt + 8'h01;
        end
    end
endmodule

// *** verif/kbc_top_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench: host port on one side, keyboard model on the other
module kbc_top_tb;
    import kbc_pkg::*;

    typedef struct packed {
        logic [7:0] code;
        logic       brk;
        logic       xlat;
        logic [7:0] exp;
    } kbc_row_t;

    logic        sys_clk, rstn, io_rd, io_wr, irq_en, xlat_en, ack_en;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata, io_rdata, rx_byte, rx_cnt, f;
    logic        irq, stat_obf, stat_ibf, stat_par_err, stat_tx_err;
    logic        kb_clk_oe, kb_data_oe, k_clk_oe, k_data_oe;
    logic        kb_clk_out, kb_data_out;
    logic        rx_par, rx_stop, ack_seen;
    wire         kb_clk  = ~(kb_clk_oe | k_clk_oe);
    wire         kb_data = ~(kb_data_oe | k_data_oe);
    int          mismatches, num_checks, n;
    kbc_row_t    rows [6] = '{'{8'h1C, 1'h0, 1'h0, 8'h1C},
        '{8'h00, 1'h0, 1'h1, 8'h00}, '{8'hFF, 1'h0, 1'h0, 8'hFF},
        '{8'h80, 1'h0, 1'h1, 8'h80}, '{8'h7F, 1'h1, 1'h1, 8'hFF},
        '{8'h1C, 1'h1, 1'h1, 8'h9C}};

    kbc_top u_kbc_top (.sys_clk(sys_clk), .rstn(rstn), .io_addr(io_addr),
        .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .irq_en(irq_en), .irq(irq),
        .xlat_en(xlat_en), .stat_obf(stat_obf), .stat_ibf(stat_ibf),
        .stat_par_err(stat_par_err), .stat_tx_err(stat_tx_err),
        .kb_clk_in(kb_clk), .kb_clk_out(kb_clk_out),
        .kb_clk_oe(kb_clk_oe), .kb_data_in(kb_data),
        .kb_data_out(kb_data_out), .kb_data_oe(kb_data_oe));

    kbc_kbd_model u_kbc_kbd_model (.kb_clk(kb_clk), .kb_data(kb_data),
        .ack_en(ack_en), .clk_oe(k_clk_oe), .data_oe(k_data_oe),
        .rx_byte(rx_byte), .rx_par(rx_par), .rx_stop(rx_stop),
        .rx_cnt(rx_cnt), .ack_seen(ack_seen));

    // 10 MHz system clock
    initial sys_clk = 1'h0;
    always #50 sys_clk = ~sys_clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One strobe cycle; returns where read data have settled
    task automatic host_io(input logic wr, input logic [15:0] a,
                           input logic [7:0] d);
        @(negedge sys_clk);
        io_addr  = a;
        io_wdata = d;
        io_rd    = ~wr;
        io_wr    = wr;
        @(negedge sys_clk);
        io_rd = 1'h0;
        io_wr = 1'h0;
    endtask

    // Bounded waits; a miss shows up in the compare that follows
    task automatic wait_obf();
        for (int i = 0; i < 300 && stat_obf !== 1'h1; i++)
            @(negedge sys_clk);
    endtask

    task automatic wait_tx();
        for (int i = 0; i < 1500 && stat_ibf !== 1'h0; i++)
            @(negedge sys_clk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog well beyond the expected run time
    initial
    begin
        #3ms;
        mismatches++;
        stop_test();
    end

    initial
    begin
        {rstn, io_rd, io_wr, irq_en, xlat_en} = 5'h00;
        io_addr  = 16'h0000;
        io_wdata = 8'h00;
        ack_en   = 1'h1;
        repeat (10) @(negedge sys_clk);
        check({kb_clk_out | kb_data_out, stat_obf, stat_ibf, stat_par_err,
               stat_tx_err, irq, kb_clk_oe, kb_data_oe}, 8'h00);
        check(io_rdata, 8'h00);
        rstn = 1'h1;
        // Ordinary receive cases, translation and interrupt gate varied
        foreach (rows[i])
        begin
            xlat_en = rows[i].xlat;
            irq_en  = i[0];
            if (rows[i].brk)
                u_kbc_kbd_model.send_byte(BRK_PREFIX, 1'h0);
            u_kbc_kbd_model.send_byte(rows[i].code, 1'h0);
            wait_obf();
            check({7'h00, irq}, {7'h00, irq_en});
            check({7'h00, ack_seen}, 8'h01);
            host_io(1'h0, DATA_PORT, 8'h00);
            check(io_rdata, rows[i].exp);
            check({7'h00, stat_obf}, 8'h00);
        end
        // Parity error, then accesses off the data port
        u_kbc_kbd_model.send_byte(8'h1C, 1'h1);
        wait_obf();
        check({6'h00, stat_par_err, ack_seen}, 8'h03);
        host_io(1'h1, 16'h0061, 8'h55);
        host_io(1'h0, 16'h0064, 8'h00);
        check({6'h00, stat_ibf, stat_obf}, 8'h01);
        check(io_rdata, 8'h9C);
        host_io(1'h0, DATA_PORT, 8'h00);
        check({io_rdata[6:0], stat_par_err}, 8'hFE);
        // Transmit with inhibit count and a refused second write
        host_io(1'h1, DATA_PORT, 8'hA5);
        check({7'h00, stat_ibf}, 8'h01);
        for (int i = 0; i < 10 && kb_clk_oe !== 1'h1; i++)
            @(negedge sys_clk);
        n = 0;
        while (kb_clk_oe === 1'h1 && n < 2000)
        begin
            @(negedge sys_clk);
            n++;
        end
        check(8'(n / 8), 8'(INH_CYC / 8));
        check(8'(n), 8'(INH_CYC));
        host_io(1'h1, DATA_PORT, 8'h77);
        wait_tx();
        repeat (300) @(negedge sys_clk);
        check(rx_cnt, 8'h01);
        check(rx_byte, 8'hA5);
        check({6'h00, ^{rx_par, rx_byte}, rx_stop}, 8'h03);
        // Unacknowledged byte reported through the output buffer
        ack_en = 1'h0;
        irq_en = 1'h1;
        host_io(1'h1, DATA_PORT, 8'h3C);
        wait_tx();
        wait_obf();
        check({6'h00, stat_tx_err, irq}, 8'h03);
        host_io(1'h0, DATA_PORT, 8'h00);
        check(io_rdata, TX_FAIL_CODE);
        ack_en = 1'h1;
        host_io(1'h1, DATA_PORT, 8'h12);
        check({7'h00, stat_tx_err}, 8'h00);
        wait_tx();
        check(rx_byte, 8'h12);
        // Let the keyboard finish its acknowledge clock first
        repeat (10) @(negedge sys_clk);
        // Fill buffer, FIFO output word and storage until inhibit
        xlat_en = 1'h0;
        for (int i = 0; i < FIFO_DEPTH + 2; i++)
            u_kbc_kbd_model.send_byte((i == 0) ? 8'hF0 : 8'(8'h11 * i), 1'h0);
        repeat (20) @(negedge sys_clk);
        check({7'h00, kb_clk_oe}, 8'h01);
        for (int i = 0; i < FIFO_DEPTH + 2; i++)
        begin
            f = (i == 0) ? 8'hF0 : 8'(8'h11 * i);
            wait_obf();
            host_io(1'h0, DATA_PORT, 8'h00);
            check(io_rdata, f);
        end
        repeat (5) @(negedge sys_clk);
        check({7'h00, stat_obf}, 8'h00);
        // Reset during the inhibit phase drops the pending byte
        host_io(1'h1, DATA_PORT, 8'h5A);
        repeat (5) @(negedge sys_clk);
        check({7'h00, kb_clk_oe}, 8'h01);
        rstn = 1'h0;
        repeat (2) @(negedge sys_clk);
        check({stat_obf, stat_ibf, stat_par_err, stat_tx_err, irq,
               kb_clk_oe, kb_data_oe, 1'h0}, 8'h00);
        rstn = 1'h1;
        repeat (5) @(negedge sys_clk);
        check({6'h00, stat_ibf, kb_clk_oe}, 8'h00);
        stop_test();
    end
endmodule
